// >>> rtl/lcd_pwm_defs.svh
// Constants for the display RAM and PWM data command decoder
//==============================================================
// Overview of operation
// - Static-mode output pin follows its stored level
// - Command 01100 loads static levels two to zero
// - Command 01101 loads static levels five to three
// - Command 10 loads segment column pointer
// - Segment pointer advances after each RAM byte that is stored
// - Pointer limit 39, 41 or 43 by multiplex
// - Out-of-range segment pointer blocks RAM writes
// - Command 01110 loads PWM channel pointer
// - Channel pointer above five blocks duty writes
// - RAM write stores full byte at pointer
// - RAM data only under register select 01
// - Duty write stores low seven bits
// - Duty data only under register select 10
// - Reset clears duty registers and both pointers
// - Reset leaves display RAM contents untouched
`ifndef LCD_PWM_DEFS_SVH
`define LCD_PWM_DEFS_SVH

//==============================================================
// Command codes, upper bits of a command byte
`define CMD_STAT_LO     5'h0c
`define CMD_STAT_HI     5'h0d
`define CMD_PWM_PTR     5'h0e
`define CMD_RAM_PTR     2'h2

// Register select field values
`define RS_COMMAND      2'h0
`define RS_RAM_DATA     2'h1
`define RS_DUTY_DATA    2'h2
`define RS_NONE         2'h3

// Multiplex modes and their last valid column
`define MUX_1_8         2'h0
`define MUX_1_6         2'h1
`define MUX_1_4         2'h2
`define COL_MAX_MUX8    6'h27
`define COL_MAX_MUX6    6'h29
`define COL_MAX_MUX4    6'h2b
`define CHAN_MAX        3'h5

// Sizes
`define RAM_WORDS       44
`define CHAN_NUM        6
`define DUTY_W          7
`define WORD_W          10
`define FIFO_DEPTH      4

// Reset values
`define COL_PTR_RST     6'h00
`define CHAN_PTR_RST    3'h0
`define STAT_RST        6'h00
`define DUTY_RST        7'h00

`endif

// >>> rtl/lcd_pwm_pkg.sv
// Types shared by the command decoder files
`default_nettype none
package lcd_pwm_pkg;
`include "lcd_pwm_defs.svh"

    typedef enum logic [1:0]
    {
        SEL_COMMAND  = `RS_COMMAND,
        SEL_RAM      = `RS_RAM_DATA,
        SEL_DUTY     = `RS_DUTY_DATA,
        SEL_NONE     = `RS_NONE
    } reg_sel_e;

    typedef enum logic [1:0]
    {
        ST_FETCH = 2'b01,
        ST_EXEC  = 2'b10
    } dec_state_e;

endpackage
`default_nettype wire

// >>> rtl/byte_fifo.sv
// Small valid/ready FIFO between link receiver and decoder
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst_b,
    // Fill side
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    // Drain side
    output logic                  o_valid,
    output logic      [WIDTH-1:0] o_data,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign o_valid = (wr_q != rd_q);
    assign o_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge i_mclk)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= i_data;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/link_byte_rx.sv
// Serial link receiver: samples the link clock and packs bytes
`timescale 1ns/1ps
`default_nettype none
module link_byte_rx (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    // Link pins
    input  wire logic       i_link_clk,
    input  wire logic       i_link_en,
    input  wire logic       i_link_sd,
    input  wire logic [1:0] i_link_rs,
    // Byte output with register select on top
    output logic            o_valid,
    output logic      [9:0] o_word,
    input  wire logic       i_ready,
    output logic            o_overrun
);
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic       clk_prev_q;
    logic [6:0] sh_q;
    logic [2:0] cnt_q;
    logic       rise;

    // Second stage is the only reader of the first
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s1_q       <= 5'h00;
            s2_q       <= 5'h00;
            clk_prev_q <= 1'b0;
        end
        else
        begin
            s1_q       <= {i_link_clk, i_link_en, i_link_sd, i_link_rs};
            s2_q       <= s1_q;
            clk_prev_q <= s2_q[4];
        end
    end

    assign rise = s2_q[4] && !clk_prev_q && s2_q[3];

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sh_q      <= 7'h00;
            cnt_q     <= 3'h0;
            o_valid   <= 1'b0;
            o_word    <= 10'h000;
            o_overrun <= 1'b0;
        end
        else
        begin
            if (o_valid && i_ready)
                o_valid <= 1'b0;
            if (!s2_q[3])
                cnt_q <= 3'h0;
            else if (rise)
            begin
                sh_q  <= {sh_q[5:0], s2_q[2]};
                cnt_q <= cnt_q + 3'h1;
                if (cnt_q == 3'h7)
                begin
                    // A full FIFO cannot hold the link off; flag the loss
                    o_word  <= {s2_q[1:0], sh_q, s2_q[2]};
                    o_valid <= 1'b1;
                    if (o_valid && !i_ready)
                        o_overrun <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/lcd_pwm_cmd_decoder.sv
// Data-path command decoder: static levels, pointers, RAM and duty writes
`timescale 1ns/1ps
`default_nettype none
`include "lcd_pwm_defs.svh"
module lcd_pwm_cmd_decoder (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    // Serial link from the host front end
    input  wire logic        i_link_clk,
    input  wire logic        i_link_en,
    input  wire logic        i_link_sd,
    input  wire logic [1:0]  i_link_rs,
    // Configuration from other command logic
    input  wire logic [1:0]  i_mux_mode,
    input  wire logic [5:0]  i_gpo_static,
    input  wire logic [5:0]  i_pwm_wave,
    // Display RAM read port for the waveform side
    input  wire logic [5:0]  i_ram_rd_addr,
    output logic      [7:0]  o_ram_rd_data,
    // State outputs
    output logic      [5:0]  o_led_output_pin,
    output logic      [41:0] o_duty_level,
    output logic      [5:0]  o_seg_col_ptr,
    output logic      [2:0]  o_pwm_ch_ptr,
    output logic             o_link_overrun
);
    //==============================================================
    // Link receiver and FIFO
    logic                      rx_valid;
    logic [`WORD_W-1:0]        rx_word;
    logic                      rx_ready;
    logic                      ff_valid;
    logic [`WORD_W-1:0]        ff_word;
    logic                      ff_ready;

    link_byte_rx u_rx (
        .i_mclk     (i_mclk),
        .i_rst_b    (i_rst_b),
        .i_link_clk (i_link_clk),
        .i_link_en  (i_link_en),
        .i_link_sd  (i_link_sd),
        .i_link_rs  (i_link_rs),
        .o_valid    (rx_valid),
        .o_word     (rx_word),
        .i_ready    (rx_ready),
        .o_overrun  (o_link_overrun)
    );

    byte_fifo #(
        .WIDTH (`WORD_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_valid (rx_valid),
        .i_data  (rx_word),
        .o_ready (rx_ready),
        .o_valid (ff_valid),
        .o_data  (ff_word),
        .i_ready (ff_ready)
    );

    //==============================================================
    // Fetch/execute sequencer
    lcd_pwm_pkg::dec_state_e   state_q;
    lcd_pwm_pkg::reg_sel_e     sel_q;
    logic [7:0]                byte_q;

    // Each byte takes two cycles, so the FIFO really absorbs bursts
    assign ff_ready = (state_q == lcd_pwm_pkg::ST_FETCH);

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= lcd_pwm_pkg::ST_FETCH;
            sel_q   <= lcd_pwm_pkg::SEL_COMMAND;
            byte_q  <= 8'h00;
        end
        else
        begin
            unique case (state_q)
                lcd_pwm_pkg::ST_FETCH:
                begin
                    if (ff_valid)
                    begin
                        sel_q   <= lcd_pwm_pkg::reg_sel_e'(ff_word[9:8]);
                        byte_q  <= ff_word[7:0];
                        state_q <= lcd_pwm_pkg::ST_EXEC;
                    end
                end
                lcd_pwm_pkg::ST_EXEC:
                begin
                    state_q <= lcd_pwm_pkg::ST_FETCH;
                end
                default:
                begin
                    state_q <= lcd_pwm_pkg::ST_FETCH;
                end
            endcase
        end
    end

    //==============================================================
    // Decode
    logic       exec;
    logic       is_cmd;
    logic       cmd_lo;
    logic       cmd_hi;
    logic       cmd_pp;
    logic       cmd_dp;
    logic [5:0] col_max;
    logic       col_ok;
    logic       chan_ok;
    logic       ram_wr;
    logic       duty_wr;

    assign exec   = (state_q == lcd_pwm_pkg::ST_EXEC);
    assign is_cmd = exec && (sel_q == lcd_pwm_pkg::SEL_COMMAND);
    assign cmd_lo = is_cmd && (byte_q[7:3] == `CMD_STAT_LO);
    assign cmd_hi = is_cmd && (byte_q[7:3] == `CMD_STAT_HI);
    assign cmd_pp = is_cmd && (byte_q[7:3] == `CMD_PWM_PTR);
    assign cmd_dp = is_cmd && (byte_q[7:6] == `CMD_RAM_PTR);

    // Limit tracks the live multiplex mode; code 3 uses the 1:8 limit
    always_comb
    begin
        unique case (i_mux_mode)
            `MUX_1_6: col_max = `COL_MAX_MUX6;
            `MUX_1_4: col_max = `COL_MAX_MUX4;
            default:  col_max = `COL_MAX_MUX8;
        endcase
    end

    assign col_ok  = (o_seg_col_ptr <= col_max);
    assign chan_ok = (o_pwm_ch_ptr <= `CHAN_MAX);
    assign ram_wr  = exec && (sel_q == lcd_pwm_pkg::SEL_RAM) && col_ok;
    assign duty_wr = exec && (sel_q == lcd_pwm_pkg::SEL_DUTY) && chan_ok;

    //==============================================================
    // Pointers
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_seg_col_ptr <= `COL_PTR_RST;
        else if (cmd_dp)
            o_seg_col_ptr <= byte_q[5:0];
        else if (ram_wr)
            o_seg_col_ptr <= o_seg_col_ptr + 6'h01;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_pwm_ch_ptr <= `CHAN_PTR_RST;
        else if (cmd_pp)
            o_pwm_ch_ptr <= byte_q[2:0];
    end

    //==============================================================
    // Static levels and output pins
    logic [5:0] stat_q;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            stat_q <= `STAT_RST;
        else if (cmd_lo)
            stat_q[2:0] <= byte_q[2:0];
        else if (cmd_hi)
            stat_q[5:3] <= byte_q[2:0];
    end

    //==============================================================
    // Duty registers, one per channel
    logic [`DUTY_W-1:0] duty_q [`CHAN_NUM];

    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_NUM; ch++)
        begin : g_chan
            always_ff @(posedge i_mclk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                    duty_q[ch] <= `DUTY_RST;
                else if (duty_wr && (o_pwm_ch_ptr == 3'(ch)))
                    duty_q[ch] <= byte_q[6:0];
            end

            always_ff @(posedge i_mclk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                    o_led_output_pin[ch] <= 1'b0;
                else if (i_gpo_static[ch])
                    o_led_output_pin[ch] <= stat_q[ch];
                else
                    o_led_output_pin[ch] <= i_pwm_wave[ch];
            end

            assign o_duty_level[ch*`DUTY_W +: `DUTY_W] = duty_q[ch];
        end
    endgenerate

    //==============================================================
    // Display RAM, deliberately without reset
    logic [7:0] ram_q [`RAM_WORDS];

    always_ff @(posedge i_mclk)
    begin
        if (ram_wr)
            ram_q[o_seg_col_ptr] <= byte_q;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_ram_rd_data <= 8'h00;
        else if (i_ram_rd_addr < 6'(`RAM_WORDS))
            o_ram_rd_data <= ram_q[i_ram_rd_addr];
        else
            o_ram_rd_data <= 8'h00;
    end

    //==============================================================
    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    logic [5:0] chk_addr_q;
    logic [7:0] chk_data_q;
    logic       chk_wr_q;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            chk_addr_q <= 6'h00;
            chk_data_q <= 8'h00;
            chk_wr_q   <= 1'b0;
        end
        else
        begin
            chk_addr_q <= o_seg_col_ptr;
            chk_data_q <= byte_q;
            chk_wr_q   <= ram_wr;
        end
    end

    a_pin_static_level:
        assert property (##1 ((o_led_output_pin & $past(i_gpo_static))
            == ($past(stat_q) & $past(i_gpo_static))))
        else $error("static pin differs from stored level");

    a_stat_low_load:
        assert property (cmd_lo |=> stat_q[2:0] == $past(byte_q[2:0])
            && $stable(stat_q[5:3]))
        else $error("low static levels not loaded");

    a_stat_high_load:
        assert property (cmd_hi |=> stat_q[5:3] == $past(byte_q[2:0])
            && $stable(stat_q[2:0]))
        else $error("high static levels not loaded");

    a_col_ptr_load:
        assert property (cmd_dp |=> o_seg_col_ptr == $past(byte_q[5:0]))
        else $error("segment pointer not loaded");

    a_col_ptr_step:
        assert property (ram_wr |=> o_seg_col_ptr == $past(o_seg_col_ptr) + 6'h01)
        else $error("segment pointer did not advance");

    // Limit worked out again from the mode, not taken from col_max
    a_col_range_gate:
        assert property (ram_wr |-> o_seg_col_ptr <= ((i_mux_mode == `MUX_1_4) ? `COL_MAX_MUX4
            : (i_mux_mode == `MUX_1_6) ? `COL_MAX_MUX6 : `COL_MAX_MUX8))
        else $error("RAM write outside column range");

    a_col_invalid_drop:
        assert property (exec && sel_q == lcd_pwm_pkg::SEL_RAM && !col_ok
            |=> $stable(o_seg_col_ptr) && !chk_wr_q)
        else $error("RAM byte taken with invalid pointer");

    a_chan_ptr_load:
        assert property (cmd_pp |=> o_pwm_ch_ptr == $past(byte_q[2:0]))
        else $error("channel pointer not loaded");

    a_chan_invalid_drop:
        assert property (exec && sel_q == lcd_pwm_pkg::SEL_DUTY && !chan_ok
            |=> o_duty_level == $past(o_duty_level))
        else $error("duty written with invalid channel");

    a_ram_byte_store:
        assert property (chk_wr_q |-> ram_q[chk_addr_q] == chk_data_q)
        else $error("RAM byte not stored at pointer");

    a_ram_select_only:
        assert property (ram_wr |-> sel_q == lcd_pwm_pkg::SEL_RAM)
        else $error("RAM write without RAM select");

    a_duty_byte_store:
        assert property (duty_wr |=> o_duty_level[$past(o_pwm_ch_ptr)*7 +: 7]
            == $past(byte_q[6:0]))
        else $error("duty level not stored");

    a_duty_select_only:
        assert property (duty_wr |-> sel_q == lcd_pwm_pkg::SEL_DUTY)
        else $error("duty write without duty select");

    a_reset_clears:
        assert property (disable iff (1'b0) $rose(i_rst_b) |-> o_seg_col_ptr == 6'h00
            && o_pwm_ch_ptr == 3'h0 && o_duty_level == 42'h0)
        else $error("pointers or duty not cleared by reset");

    a_unknown_cmd_hold:
        assert property (is_cmd && !(cmd_lo || cmd_hi || cmd_pp || cmd_dp)
            |=> $stable(stat_q) && $stable(o_seg_col_ptr)
            && $stable(o_pwm_ch_ptr) && $stable(o_duty_level))
        else $error("unknown command changed state");

    a_fetch_stall:
        assert property (exec |-> !ff_ready ##1 ff_ready)
        else $error("decoder did not stall for execute");
endmodule
`default_nettype wire

// >>> verification/link_host_model.sv
// Host-side model that frames command and data bytes onto the serial link
`timescale 1ns/1ps
`default_nettype none
module link_host_model #(
    parameter real HALF_NS = 24.0
) (
    // Link pins
    output var logic       o_link_clk,
    output var logic       o_link_en,
    output var logic       o_link_sd,
    output var logic [1:0] o_link_rs
);
    //==============================================================
    // Idle link: clock stands still low outside frames
    initial
    begin
        o_link_clk = 1'b0;
        o_link_en  = 1'b0;
        o_link_sd  = 1'b0;
        o_link_rs  = 2'h3;
    end

    //==============================================================
    // One frame, MSB first, register select held for the whole byte
    task automatic send_byte(input logic [1:0] rs, input logic [7:0] data);
        o_link_en = 1'b1;
        o_link_rs = rs;
        for (int b = 7; b >= 0; b--)
        begin
            o_link_sd = data[b];
            #(HALF_NS);
            o_link_clk = 1'b1;
            #(HALF_NS);
            o_link_clk = 1'b0;
        end
        #(HALF_NS);
        o_link_en = 1'b0;
        // Released lines flip so a stale value is never mistaken for data
        o_link_sd = ~o_link_sd;
        o_link_rs = ~o_link_rs;
        #(HALF_NS);
    endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the data-path command decoder, driven through its link
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int N_ROWS = 19;
    typedef struct packed
    {
        logic [1:0]  rs;
        logic [7:0]  data;
        logic [1:0]  mux;
        logic [5:0]  seg;
        logic [2:0]  ch;
        logic [5:0]  led;
        logic [41:0] duty;
    } row_s;

    //==============================================================
    // Signals
    logic        i_mclk;
    logic        i_rst_b;
    logic        link_clk;
    logic        link_en;
    logic        link_sd;
    logic [1:0]  link_rs;
    logic [1:0]  i_mux_mode;
    logic [5:0]  i_gpo_static;
    logic [5:0]  i_pwm_wave;
    logic [5:0]  i_ram_rd_addr;
    logic [7:0]  ram_rd_data;
    logic [5:0]  led_pin;
    logic [41:0] duty_level;
    logic [5:0]  seg_ptr;
    logic [2:0]  ch_ptr;
    logic        overrun;
    int          error_cnt;
    int          n_tests;

    // Rows run in order; each gives the state expected after its byte
    row_s rows [N_ROWS] = '{
        '{2'h0, 8'h65, 2'h0, 6'h00, 3'h0, 6'h05, 42'h0},
        '{2'h0, 8'h6e, 2'h0, 6'h00, 3'h0, 6'h35, 42'h0},
        '{2'h0, 8'ha6, 2'h0, 6'h26, 3'h0, 6'h35, 42'h0},
        '{2'h1, 8'hc3, 2'h0, 6'h27, 3'h0, 6'h35, 42'h0},
        '{2'h1, 8'h5a, 2'h0, 6'h28, 3'h0, 6'h35, 42'h0},
        '{2'h1, 8'h11, 2'h0, 6'h28, 3'h0, 6'h35, 42'h0},
        '{2'h0, 8'h75, 2'h0, 6'h28, 3'h5, 6'h35, 42'h0},
        '{2'h2, 8'hff, 2'h0, 6'h28, 3'h5, 6'h35, 42'h3f800000000},
        '{2'h0, 8'h76, 2'h0, 6'h28, 3'h6, 6'h35, 42'h3f800000000},
        '{2'h2, 8'h22, 2'h0, 6'h28, 3'h6, 6'h35, 42'h3f800000000},
        '{2'h3, 8'h80, 2'h0, 6'h28, 3'h6, 6'h35, 42'h3f800000000},
        '{2'h0, 8'h41, 2'h0, 6'h28, 3'h6, 6'h35, 42'h3f800000000},
        '{2'h1, 8'h65, 2'h2, 6'h29, 3'h6, 6'h35, 42'h3f800000000},
        '{2'h1, 8'h3c, 2'h1, 6'h2a, 3'h6, 6'h35, 42'h3f800000000},
        '{2'h1, 8'h77, 2'h1, 6'h2a, 3'h6, 6'h35, 42'h3f800000000},
        '{2'h0, 8'h70, 2'h3, 6'h2a, 3'h0, 6'h35, 42'h3f800000000},
        '{2'h2, 8'h6d, 2'h3, 6'h2a, 3'h0, 6'h35, 42'h3f80000006d},
        '{2'h0, 8'h80, 2'h0, 6'h00, 3'h0, 6'h35, 42'h3f80000006d},
        '{2'h1, 8'ha5, 2'h0, 6'h01, 3'h0, 6'h35, 42'h3f80000006d}
    };

    //==============================================================
    // Instances
    link_host_model i_host (
        .o_link_clk (link_clk),
        .o_link_en  (link_en),
        .o_link_sd  (link_sd),
        .o_link_rs  (link_rs)
    );

    lcd_pwm_cmd_decoder i_dut (
        .i_mclk           (i_mclk),
        .i_rst_b          (i_rst_b),
        .i_link_clk       (link_clk),
        .i_link_en        (link_en),
        .i_link_sd        (link_sd),
        .i_link_rs        (link_rs),
        .i_mux_mode       (i_mux_mode),
        .i_gpo_static     (i_gpo_static),
        .i_pwm_wave       (i_pwm_wave),
        .i_ram_rd_addr    (i_ram_rd_addr),
        .o_ram_rd_data    (ram_rd_data),
        .o_led_output_pin (led_pin),
        .o_duty_level     (duty_level),
        .o_seg_col_ptr    (seg_ptr),
        .o_pwm_ch_ptr     (ch_ptr),
        .o_link_overrun   (overrun)
    );

    //==============================================================
    // Helpers
    task automatic check(input string name, input logic [41:0] exp, input logic [41:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic check_state(input row_s r);
        check("seg_ptr", 42'(r.seg), 42'(seg_ptr));
        check("ch_ptr", 42'(r.ch), 42'(ch_ptr));
        check("led_pin", 42'(r.led), 42'(led_pin));
        check("duty_level", r.duty, duty_level);
    endtask

    task automatic read_ram(input logic [5:0] addr, input logic [7:0] exp);
        i_ram_rd_addr = addr;
        tick(2);
        check("ram_rd_data", 42'(exp), 42'(ram_rd_data));
    endtask

    //==============================================================
    // Clock and watchdog; a byte frame takes about 0.43 us
    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    initial
    begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    //==============================================================
    // Main sequence
    initial
    begin
        error_cnt     = 0;
        n_tests       = 0;
        i_rst_b       = 1'b0;
        i_mux_mode    = 2'h0;
        i_gpo_static  = 6'h3f;
        i_pwm_wave    = 6'h00;
        i_ram_rd_addr = 6'h00;
        tick(10);
        i_rst_b = 1'b1;
        tick(5);
        for (int i = 0; i < N_ROWS; i++)
        begin
            i_mux_mode = rows[i].mux;
            i_host.send_byte(rows[i].rs, rows[i].data);
            tick(12);
            check_state(rows[i]);
        end
        read_ram(6'h26, 8'hc3);
        read_ram(6'h27, 8'h5a);
        read_ram(6'h28, 8'h65);
        read_ram(6'h29, 8'h3c);
        read_ram(6'h00, 8'ha5);
        check("overrun", 42'h0, 42'(overrun));
        // Mixed static and waveform pins
        i_gpo_static = 6'h07;
        i_pwm_wave   = 6'h2a;
        tick(3);
        check("led_pin", 42'h2d, 42'(led_pin));
        i_gpo_static = 6'h3f;
        // Pin reset in mid-run keeps display RAM
        i_rst_b = 1'b0;
        tick(3);
        i_rst_b = 1'b1;
        tick(3);
        check_state('{2'h0, 8'h00, 2'h0, 6'h00, 3'h0, 6'h00, 42'h0});
        read_ram(6'h26, 8'hc3);
        // Back-to-back frames pass the receiver and FIFO with no overrun
        i_host.send_byte(2'h0, 8'h81);
        i_host.send_byte(2'h1, 8'h3e);
        i_host.send_byte(2'h1, 8'hd4);
        tick(12);
        check("seg_ptr", 42'h3, 42'(seg_ptr));
        read_ram(6'h01, 8'h3e);
        read_ram(6'h02, 8'hd4);
        check("overrun", 42'h0, 42'(overrun));
        give_verdict();
    end
endmodule
`default_nettype wire
